// [verilog/amc_pkg.sv]
package amc_pkg;

  localparam int          CODE_W      = 18;
  localparam int          CH_W        = 3;
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam int          CNT_W       = 24;

  // register byte offsets
  localparam logic [3:0]  OFS_CTRL    = 4'h0;
  localparam logic [3:0]  OFS_STATUS  = 4'h4;
  localparam logic [3:0]  OFS_LSB     = 4'h8;
  localparam logic [3:0]  OFS_RESULT  = 4'hC;

  // control field positions and reset value
  localparam int          CTRL_RES_EN = 0;
  localparam logic [0:0]  CTRL_RST    = 1'h1;

  // status field positions
  localparam int          ST_REF_SEL  = 0;
  localparam int          ST_SPAN     = 1;
  localparam int          ST_PD_REQ_N = 2;
  localparam int          ST_PWR_LO   = 3;
  localparam int          ST_PWR_HI   = 4;
  localparam int          ST_SETTLE   = 5;
  localparam int          ST_BOOT_REF = 6;
  localparam int          ST_BOOT_OK  = 7;

  // result register: code in the low bits, channel above it
  localparam int          RES_CH_LSB  = 18;
  localparam int          RES_VLD     = 21;

  // code step in picovolts: full-scale span / 262144
  localparam longint      CODE_STEPS  = 262144;
  localparam logic [31:0] LSB_WIDE_PV = 32'h048C_2658;
  localparam logic [31:0] LSB_NARR_PV = 32'h0246_132C;

  // timing
  localparam int          CLK_MHZ          = 250;
  localparam int          SPAN_SETTLE_US   = 80;
  localparam int          SPAN_SETTLE_CYC  = SPAN_SETTLE_US * CLK_MHZ;
  localparam int          RECOVERY_CYC_DEF = 1000;

  localparam logic [CODE_W-1:0] SIGN_FLIP = 18'h20000;

  typedef enum logic [1:0] {
    PWR_RUN      = 2'h0,
    PWR_STANDBY  = 2'h1,
    PWR_SHUTDOWN = 2'h3
  } amc_pwr_t;

  typedef struct packed {
    logic ref_sel;
    logic span_sel;
    logic pd_req_n;
  } amc_pins_t;

  typedef struct packed {
    logic bandgap_en;
    logic ref_io_oe;
    logic ref_buf_en;
    logic regulator_en;
    logic core_en;
    logic span_wide;
  } amc_analog_t;

  typedef struct packed {
    logic              valid;
    logic [CH_W-1:0]   channel;
    logic [CODE_W-1:0] code;
  } amc_result_t;

endpackage

// [verilog/amc_sync.sv]
`timescale 1ns/1ns
module amc_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic d,
  output logic      q
);
  logic meta_ff;
  logic q_ff;

  always_ff @(posedge clk) begin
    // reset preloads the pin level, so no false edge follows reset release
    if (srst) begin
      meta_ff <= d;
      q_ff    <= d;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule

// [verilog/amc_code_fmt.sv]
`timescale 1ns/1ns
module amc_code_fmt (
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         raw_valid,
  input  wire logic [amc_pkg::CH_W-1:0]     raw_channel,
  input  wire logic [amc_pkg::CODE_W-1:0]   raw_code,
  output amc_pkg::amc_result_t              result
);
  amc_pkg::amc_result_t result_ff;

  // offset binary from the core becomes two's complement by inverting the msb
  always_ff @(posedge clk) begin
    if (srst) begin
      result_ff <= '0;
    end else begin
      result_ff.valid <= raw_valid;
      if (raw_valid) begin
        result_ff.channel <= raw_channel;
        result_ff.code    <= raw_code ^ amc_pkg::SIGN_FLIP;
      end
    end
  end

  assign result = result_ff;
endmodule

// [verilog/amc_mode_ctrl.sv]
`timescale 1ns/1ns
module amc_mode_ctrl #(
  parameter int SETTLE_CYC   = amc_pkg::SPAN_SETTLE_CYC,
  parameter int RECOVERY_CYC = amc_pkg::RECOVERY_CYC_DEF
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  // mode pins from the host
  input  wire amc_pkg::amc_pins_t            pins,
  // raw conversion results from the converter core
  input  wire logic                          raw_valid,
  input  wire logic [amc_pkg::CH_W-1:0]      raw_channel,
  input  wire logic [amc_pkg::CODE_W-1:0]    raw_code,
  // analog control, result and settle status outputs
  output amc_pkg::amc_analog_t               analog,
  output amc_pkg::amc_result_t               result,
  output logic                               settle_busy,
  // Avalon-MM slave
  input  wire logic [amc_pkg::ADDR_W-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [amc_pkg::DATA_W-1:0]    avs_writedata,
  output logic [amc_pkg::DATA_W-1:0]         avs_readdata,
  output logic                               avs_waitrequest
);

  logic                       ref_sel_s;
  logic                       span_s;
  logic                       pd_req_n_s;
  logic                       span_prev_ff;
  logic                       boot_ref_ff;
  logic                       boot_ok_ff;
  logic                       res_en_ff;
  logic                       ack_ff;
  logic [amc_pkg::DATA_W-1:0] rdata_ff;
  logic [amc_pkg::CNT_W-1:0]  settle_ff;
  logic [amc_pkg::CNT_W-1:0]  nxt_settle;
  logic [amc_pkg::DATA_W-1:0] nxt_rdata;
  logic [amc_pkg::DATA_W-1:0] status;
  logic [amc_pkg::DATA_W-1:0] lsb_pv;
  logic                       req;
  logic                       pd_sel_shutdown;
  logic                       fmt_valid;
  amc_pkg::amc_pwr_t          pwr_ff;
  amc_pkg::amc_pwr_t          nxt_pwr;
  amc_pkg::amc_result_t       fmt_res;
  amc_pkg::amc_result_t       result_ff;

  localparam logic [amc_pkg::CNT_W-1:0] SETTLE_LOAD   = amc_pkg::CNT_W'(SETTLE_CYC);
  localparam logic [amc_pkg::CNT_W-1:0] RECOVERY_LOAD = amc_pkg::CNT_W'(RECOVERY_CYC);

  // synchronised copies feed only status, the code step weight, settle timing and the power state
  amc_sync u_sync_ref (
    .clk  (clk),
    .srst (srst),
    .d    (pins.ref_sel),
    .q    (ref_sel_s)
  );

  amc_sync u_sync_span (
    .clk  (clk),
    .srst (srst),
    .d    (pins.span_sel),
    .q    (span_s)
  );

  amc_sync u_sync_pd (
    .clk  (clk),
    .srst (srst),
    .d    (pins.pd_req_n),
    .q    (pd_req_n_s)
  );

  // analog enables come straight from the pins: no clock sits in the path,
  // so a pin change reaches the analog section without waiting for an edge
  // span high picks standby, span low picks shutdown
  assign pd_sel_shutdown = ~pins.span_sel;

  always_comb begin
    analog.span_wide    = pins.span_sel;
    analog.core_en      = pins.pd_req_n;
    analog.regulator_en = pins.pd_req_n | ~pd_sel_shutdown;
    analog.bandgap_en   = pins.ref_sel & analog.regulator_en;
    // the pin is driven only when the band-gap sources it; in external mode
    // it stays a high-impedance input fed by the host's reference
    analog.ref_io_oe    = pins.ref_sel & analog.regulator_en;
    analog.ref_buf_en   = analog.regulator_en;
  end

  // reference mode seen on the first cycle after reset release
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_ref_ff <= 1'b0;
      boot_ok_ff  <= 1'b0;
    end else if (!boot_ok_ff) begin
      boot_ref_ff <= pins.ref_sel;
      boot_ok_ff  <= 1'b1;
    end
  end

  // power state tracking for status and recovery timing
  always_comb begin
    nxt_pwr = pwr_ff;
    unique case (pwr_ff)
      amc_pkg::PWR_RUN: begin
        if (!pd_req_n_s) begin
          nxt_pwr = span_s ? amc_pkg::PWR_STANDBY : amc_pkg::PWR_SHUTDOWN;
        end
      end
      amc_pkg::PWR_STANDBY,
      amc_pkg::PWR_SHUTDOWN: begin
        if (pd_req_n_s) begin
          nxt_pwr = amc_pkg::PWR_RUN;
        end
      end
      default: begin
        nxt_pwr = amc_pkg::PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr_ff <= amc_pkg::PWR_RUN;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // settle window: restarted by a span change or by leaving power-down;
  // the host is expected to hold off conversions while it runs
  always_ff @(posedge clk) begin
    if (srst) begin
      span_prev_ff <= span_s;
    end else begin
      span_prev_ff <= span_s;
    end
  end

  always_comb begin
    nxt_settle = settle_ff;
    if (pwr_ff != amc_pkg::PWR_RUN && nxt_pwr == amc_pkg::PWR_RUN) begin
      nxt_settle = RECOVERY_LOAD;
    end else if (span_s != span_prev_ff) begin
      nxt_settle = SETTLE_LOAD;
    end else if (settle_ff != '0) begin
      nxt_settle = settle_ff - amc_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      settle_ff <= '0;
    end else begin
      settle_ff <= nxt_settle;
    end
  end

  assign settle_busy = (settle_ff != '0);

  // result formatting
  amc_code_fmt u_fmt (
    .clk         (clk),
    .srst        (srst),
    .raw_valid   (raw_valid),
    .raw_channel (raw_channel),
    .raw_code    (raw_code),
    .result      (fmt_res)
  );

  assign fmt_valid = fmt_res.valid & res_en_ff;

  // result output and register hold the last formatted code; the enable lets
  // software freeze the value while it reads it
  always_ff @(posedge clk) begin
    if (srst) begin
      result_ff <= '0;
    end else begin
      result_ff.valid <= fmt_valid;
      if (fmt_valid) begin
        result_ff.channel <= fmt_res.channel;
        result_ff.code    <= fmt_res.code;
      end
    end
  end

  assign result = result_ff;

  // code step weight follows the live span
  assign lsb_pv = span_s ? amc_pkg::LSB_WIDE_PV : amc_pkg::LSB_NARR_PV;

  always_comb begin
    status                        = '0;
    status[amc_pkg::ST_REF_SEL]   = ref_sel_s;
    status[amc_pkg::ST_SPAN]      = span_s;
    status[amc_pkg::ST_PD_REQ_N]  = pd_req_n_s;
    status[amc_pkg::ST_PWR_LO]    = pwr_ff[0];
    status[amc_pkg::ST_PWR_HI]    = pwr_ff[1];
    status[amc_pkg::ST_SETTLE]    = settle_busy;
    status[amc_pkg::ST_BOOT_REF]  = boot_ref_ff;
    status[amc_pkg::ST_BOOT_OK]   = boot_ok_ff;
  end

  // bus slave: every access waits exactly one cycle, then completes
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      res_en_ff <= amc_pkg::CTRL_RST;
    end else if (avs_write && ack_ff && avs_address == amc_pkg::OFS_CTRL) begin
      res_en_ff <= avs_writedata[amc_pkg::CTRL_RES_EN];
    end
  end

  always_comb begin
    nxt_rdata = '0;
    unique case (avs_address)
      amc_pkg::OFS_CTRL: begin
        nxt_rdata[amc_pkg::CTRL_RES_EN] = res_en_ff;
      end
      amc_pkg::OFS_STATUS: begin
        nxt_rdata = status;
      end
      amc_pkg::OFS_LSB: begin
        nxt_rdata = lsb_pv;
      end
      amc_pkg::OFS_RESULT: begin
        nxt_rdata[amc_pkg::CODE_W-1:0]                    = result_ff.code;
        nxt_rdata[amc_pkg::RES_VLD-1:amc_pkg::RES_CH_LSB] = result_ff.channel;
        nxt_rdata[amc_pkg::RES_VLD]                       = result_ff.valid;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= '0;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata = rdata_ff;

endmodule

// [testbench/amc_mode_ctrl_assertions.sv]
`timescale 1ns/1ns
module amc_mode_ctrl_checker #(
  parameter int SETTLE_CYC   = 20,
  parameter int RECOVERY_CYC = 10
) (
  input wire logic                       clk,
  input wire logic                       srst,
  input wire amc_pkg::amc_pins_t         pins,
  input wire logic                       raw_valid,
  input wire logic [amc_pkg::CH_W-1:0]   raw_channel,
  input wire logic [amc_pkg::CODE_W-1:0] raw_code,
  input wire amc_pkg::amc_analog_t       analog,
  input wire amc_pkg::amc_result_t       result,
  input wire logic                       settle_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // length of the current settle window; a reload would stretch it, so the bench avoids reloads
  int busy_len_ff;
  always_ff @(posedge clk) begin
    if (srst || !settle_busy) busy_len_ff <= 0;
    else busy_len_ff <= busy_len_ff + 1;
  end

  sequence s_span_evt;
    $changed(pins.span_sel) && pins.pd_req_n && $past(pins.pd_req_n);
  endsequence
  sequence s_settle_up;
    ##3 settle_busy;
  endsequence

  property p_int_ref;
    pins.ref_sel && pins.pd_req_n |-> analog.bandgap_en && analog.ref_io_oe;
  endproperty
  property p_ext_ref;
    !pins.ref_sel |-> !analog.bandgap_en && !analog.ref_io_oe;
  endproperty
  property p_buf_on;
    pins.pd_req_n |-> analog.ref_buf_en && analog.core_en;
  endproperty
  property p_span;
    analog.span_wide == pins.span_sel;
  endproperty
  property p_shutdown;
    !pins.pd_req_n && !pins.span_sel |-> analog == '0;
  endproperty
  property p_standby;
    !pins.pd_req_n && pins.span_sel |->
      !analog.core_en && analog.regulator_en && analog.bandgap_en == pins.ref_sel;
  endproperty
  property p_settle_start;
    s_span_evt |-> s_settle_up;
  endproperty
  property p_settle_len;
    $fell(settle_busy) |-> busy_len_ff == SETTLE_CYC || busy_len_ff == RECOVERY_CYC;
  endproperty
  property p_result;
    result.valid |-> $past(raw_valid, 2) && result.channel == $past(raw_channel, 2)
      && result.code == ($past(raw_code, 2) ^ amc_pkg::SIGN_FLIP);
  endproperty

  a_int_ref: assert property (p_int_ref)
    else $error("band-gap off in internal mode");
  a_ext_ref: assert property (p_ext_ref)
    else $error("band-gap on in external mode");
  a_buf_on: assert property (p_buf_on)
    else $error("buffer or core off while running");
  a_span: assert property (p_span)
    else $error("span does not follow pin");
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown leaves a block powered");
  a_standby: assert property (p_standby)
    else $error("standby enables wrong");
  a_settle_start: assert property (p_settle_start)
    else $error("settle window did not start");
  a_settle_len: assert property (p_settle_len)
    else $error("settle window length wrong");
  a_result: assert property (p_result)
    else $error("result code or timing wrong");
endmodule

bind amc_mode_ctrl amc_mode_ctrl_checker #(
  .SETTLE_CYC(SETTLE_CYC),
  .RECOVERY_CYC(RECOVERY_CYC)
) chk_u (.clk, .srst, .pins, .raw_valid, .raw_channel, .raw_code, .analog, .result, .settle_busy);

// [testbench/amc_host_model.sv]
`timescale 1ns/1ns
module amc_host_model #(
  parameter int HOLD_CYC = 20
) (
  input wire logic         clk,
  input wire logic         srst,
  input wire amc_pkg::amc_pins_t want,
  output amc_pkg::amc_pins_t     pins_ff,
  output logic             ready,
  output logic             ext_ref_on
);
  int hold_ff;
  always_ff @(posedge clk) begin
    pins_ff <= want;
    if (srst) hold_ff <= 0;
    else if (want.span_sel != pins_ff.span_sel || (want.pd_req_n && !pins_ff.pd_req_n))
      hold_ff <= HOLD_CYC;
    else if (hold_ff != 0) hold_ff <= hold_ff - 1;
  end
  assign ready = (hold_ff == 0);
  // host reference drives the shared pin only while the device leaves it as an input
  assign ext_ref_on = ~pins_ff.ref_sel;
endmodule

// [testbench/tb_amc_mode_ctrl.sv]
`timescale 1ns/1ns
module tb_amc_mode_ctrl;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  amc_pkg::amc_pins_t   want;
  amc_pkg::amc_pins_t   pins;
  logic                 ready;
  logic                 ext_ref;
  logic                 raw_valid;
  logic [2:0]           raw_channel;
  logic [17:0]          raw_code;
  amc_pkg::amc_analog_t analog;
  amc_pkg::amc_result_t result;
  logic                 settle_busy;
  logic [3:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [31:0]          rd;
  logic [2:0]           g;
  logic                 r;
  int                   n_fail = 0;
  int                   num_checks = 0;
  int                   n_res = 0;

  always #2 clk = ~clk;

  amc_host_model #(.HOLD_CYC(20)) host_u (.clk, .srst, .want, .pins_ff(pins), .ready,
    .ext_ref_on(ext_ref));
  amc_mode_ctrl #(.SETTLE_CYC(20), .RECOVERY_CYC(10)) dut_u (.clk, .srst, .pins, .raw_valid,
    .raw_channel, .raw_code, .analog, .result, .settle_busy, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

  always @(posedge clk) begin
    if (!srst && result.valid === 1'b1) n_res <= n_res + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_fail++;
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // the settle window only opens a few edges after the pins move, hence the lead-in
  task automatic quiet;
    int n;
    n = 0;
    repeat (5) @(posedge clk);
    while ((ready !== 1'b1 || settle_busy !== 1'b0) && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) n_fail++;
  endtask

  task automatic pulse(input logic [2:0] c, input logic [17:0] k);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_channel <= c;
    raw_code <= k;
  endtask

  initial begin
    want = 3'h7;
    raw_valid = 1'b0;
    raw_channel = 3'h0;
    raw_code = 18'h00000;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, amc_pkg::OFS_CTRL, 32'h0, rd);
    chk("ctrl", rd, 32'h0000_0001);
    bus(1'b0, amc_pkg::OFS_STATUS, 32'h0, rd);
    chk("status", rd, 32'h0000_00C7);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
    bus(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", rd, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      g = 3'(i ^ (i >> 1));
      @(posedge clk);
      want <= g;
      quiet();
      r = g[0] | g[1];
      chk("analog", 32'(analog), {26'h0, g[2] & r, g[2] & r, r, r, g[0], g[1]});
      chk("ref owner", {31'h0, ext_ref & analog.ref_io_oe}, 32'h0);
      bus(1'b0, amc_pkg::OFS_STATUS, 32'h0, rd);
      chk("status", rd & 32'h3F, {27'h0, g[0] ? 2'h0 : (g[1] ? 2'h1 : 2'h3), g[0], g[1], g[2]});
      bus(1'b0, amc_pkg::OFS_LSB, 32'h0, rd);
      chk("lsb", rd, g[1] ? amc_pkg::LSB_WIDE_PV : amc_pkg::LSB_NARR_PV);
    end
    $display("test pin modes done");
    @(posedge clk);
    want <= 3'h7;
    quiet();
    for (int c = 0; c < 8; c++) pulse(3'(c), (c == 7) ? 18'h3FFFF : {3'(c), 15'h0});
    @(posedge clk);
    raw_valid <= 1'b0;
    bus(1'b0, amc_pkg::OFS_RESULT, 32'h0, rd);
    chk("result", rd & 32'h1F_FFFF, {11'h0, 3'h7, 18'h1FFFF});
    bus(1'b1, amc_pkg::OFS_CTRL, 32'h0, rd);
    pulse(3'h3, 18'h00001);
    @(posedge clk);
    raw_valid <= 1'b0;
    bus(1'b0, amc_pkg::OFS_RESULT, 32'h0, rd);
    chk("dropped", rd & 32'h1F_FFFF, {11'h0, 3'h7, 18'h1FFFF});
    chk("pulses", 32'(n_res), 32'h0000_0008);
    bus(1'b1, amc_pkg::OFS_CTRL, 32'h1, rd);
    bus(1'b0, amc_pkg::OFS_CTRL, 32'h0, rd);
    chk("ctrl", rd, 32'h0000_0001);
    $display("test results done");
    @(posedge clk);
    want <= 3'h3;
    quiet();
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, amc_pkg::OFS_STATUS, 32'h0, rd);
    chk("boot", rd, 32'h0000_0086);
    $display("test second reset done");
    wrap_up();
  end

  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule
